/* File: flash_host_pkg.sv */
package flash_host_pkg;

  localparam int unsigned clk_mhz = 50;
  localparam int unsigned strobe_high_pulse_min_ns = 150;
  localparam int unsigned write_pulse_ns = 90;
  localparam int unsigned write_high_ns = 90;
  localparam int unsigned read_access_ns = 55;
  localparam int unsigned address_hold_ns = 50;
  localparam int unsigned strobe_high_cycles = (strobe_high_pulse_min_ns * clk_mhz + 999) / 1000;
  localparam int unsigned write_low_cycles = (write_pulse_ns * clk_mhz + 999) / 1000;
  localparam int unsigned write_high_cycles = (write_high_ns * clk_mhz + 999) / 1000;
  localparam int unsigned read_cycles = (read_access_ns * clk_mhz + 999) / 1000 + 1;
  localparam int unsigned hold_cycles = (address_hold_ns * clk_mhz + 999) / 1000;

  localparam logic [15:0] boot_first = 16'h0000;
  localparam logic [15:0] boot_last = 16'h1FFF;
  localparam logic [15:0] ident_maker_addr = 16'h0000;
  localparam logic [15:0] ident_device_addr = 16'h0001;

  // command pattern values are fixed here as localparams; board integration cannot override them
  localparam logic [14:0] unlock_addr1 = 15'h5555;
  localparam logic [14:0] unlock_addr2 = 15'h2AAA;
  localparam logic [7:0] unlock_data1 = 8'hAA;
  localparam logic [7:0] unlock_data2 = 8'h55;
  localparam logic [7:0] cmd_program = 8'hA0;
  localparam logic [7:0] cmd_erase_setup = 8'h80;
  localparam logic [7:0] cmd_chip_erase = 8'h10;
  localparam logic [7:0] cmd_ident_entry = 8'h90;
  localparam logic [7:0] cmd_ident_exit = 8'hF0;
  localparam logic [7:0] cmd_lockout = 8'h40;
  localparam int unsigned toggle_bit = 6;

  typedef enum logic [2:0] {
    op_read,
    op_program,
    op_chip_erase,
    op_ident_entry,
    op_ident_exit,
    op_lockout
  } op_t;

  typedef struct packed {
    op_t op;
    logic [15:0] addr;
    logic [7:0] data;
  } host_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } bus_word_t;

endpackage

/* File: flash_strobe.sv */
`timescale 1ns/1ps
module flash_strobe
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // cycle request
  input wire logic start,
  input wire logic is_write,
  output logic busy,
  output logic done,
  // strobe drive
  output logic strobe_n,
  output logic sample
);

  typedef enum {s_idle, s_low, s_high} strobe_state_t;
  strobe_state_t state;
  logic [7:0] count;
  logic writing;

  function automatic logic [7:0] low_len(input logic w);
    return w ? 8'(write_low_cycles) : 8'(read_cycles);
  endfunction

  // one cycle: strobe low for its pulse, then high for the recovery time
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= s_idle;
      count <= 8'h00;
      writing <= 1'b0;
      strobe_n <= 1'b1;
      sample <= 1'b0;
      done <= 1'b0;
    end else begin
      sample <= 1'b0;
      done <= 1'b0;
      case (state)
        s_idle: begin
          if (start) begin
            state <= s_low;
            writing <= is_write;
            strobe_n <= 1'b0;
            count <= low_len(is_write);
          end
        end
        s_low: begin
          if (count == 8'h01) begin
            state <= s_high;
            strobe_n <= 1'b1;
            sample <= !writing;
            // the high time covers both write recovery and the toggle pulse minimum
            count <= 8'(strobe_high_cycles > write_high_cycles ?
                        strobe_high_cycles : write_high_cycles);
          end else begin
            count <= count - 8'h01;
          end
        end
        s_high: begin
          if (count == 8'h01) begin
            state <= s_idle;
            done <= 1'b1;
          end else begin
            count <= count - 8'h01;
          end
        end
        default: state <= s_idle;
      endcase
    end
  end

  assign busy = (state != s_idle);

endmodule

/* File: flash_host.sv */
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // user request
  input wire logic req_valid,
  input wire host_req_t req,
  output logic req_ready,
  // user answer
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic resp_refused,
  output logic ident_mode,
  output logic lockout_sent,
  // flash pins
  output logic [15:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n
);

  typedef enum {h_idle, h_seq, h_wait, h_read, h_poll, h_answer} host_state_t;
  host_state_t state;
  host_req_t cur;
  logic [2:0] step;
  logic [2:0] steps;
  logic have_prev;
  logic [7:0] prev;
  logic cyc_start;
  logic cyc_write;
  logic cyc_busy;
  logic cyc_done;
  logic strobe_n;
  logic sample;
  bus_word_t word;
  logic [7:0] answer;
  logic refused;

  function automatic bus_word_t cmd_word(input op_t op, input logic [2:0] n,
                                         input host_req_t r);
    bus_word_t w;
    w.addr = {1'b0, unlock_addr1};
    w.data = unlock_data1;
    case (n)
      3'd1: begin
        w.addr = {1'b0, unlock_addr2};
        w.data = unlock_data2;
      end
      3'd2: begin
        case (op)
          op_program: w.data = cmd_program;
          op_chip_erase: w.data = cmd_erase_setup;
          op_ident_entry: w.data = cmd_ident_entry;
          op_ident_exit: w.data = cmd_ident_exit;
          default: w.data = cmd_lockout;
        endcase
      end
      3'd3: begin
        if (op == op_program) begin
          w = {r.addr, r.data};
        end else begin
          w.data = unlock_data1;
        end
      end
      3'd4: begin
        w.addr = {1'b0, unlock_addr2};
        w.data = unlock_data2;
      end
      3'd5: w.data = (op == op_chip_erase) ? cmd_chip_erase : cmd_lockout;
      default: w.data = unlock_data1;
    endcase
    // program data keeps its full address; command cycles use only the low 15 bits
    if (!(op == op_program && n == 3'd3)) begin
      w.addr[15] = 1'b0;
    end
    return w;
  endfunction

  function automatic logic [2:0] op_steps(input op_t op);
    case (op)
      op_program: return 3'd4;
      op_chip_erase: return 3'd6;
      op_lockout: return 3'd6;
      default: return 3'd3;
    endcase
  endfunction

  function automatic logic in_boot(input logic [15:0] a);
    return (a >= boot_first) && (a <= boot_last);
  endfunction

  assign word = cmd_word(cur.op, step, cur);

  flash_strobe u_strobe (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(cyc_start),
    .is_write(cyc_write),
    .busy(cyc_busy),
    .done(cyc_done),
    .strobe_n(strobe_n),
    .sample(sample)
  );

  // sequencing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= h_idle;
      cur <= '0;
      step <= 3'd0;
      steps <= 3'd0;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      have_prev <= 1'b0;
      prev <= 8'h00;
      answer <= 8'h00;
      refused <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      case (state)
        h_idle: begin
          refused <= 1'b0;
          if (req_valid) begin
            cur <= req;
            step <= 3'd0;
            steps <= op_steps(req.op);
            if (req.op == op_read) begin
              state <= h_read;
              cyc_start <= 1'b1;
              cyc_write <= 1'b0;
            end else if (req.op == op_program && lockout_sent && in_boot(req.addr)) begin
              refused <= 1'b1;
              state <= h_answer;
            end else begin
              state <= h_seq;
              cyc_start <= 1'b1;
              cyc_write <= 1'b1;
            end
          end
        end
        h_seq: begin
          if (cyc_done) begin
            if (step == steps - 3'd1) begin
              have_prev <= 1'b0;
              if (cur.op == op_program || cur.op == op_chip_erase) begin
                state <= h_poll;
                cyc_start <= 1'b1;
                cyc_write <= 1'b0;
              end else begin
                state <= h_answer;
              end
            end else begin
              step <= step + 3'd1;
              cyc_start <= 1'b1;
            end
          end
        end
        h_read: begin
          if (sample) begin
            answer <= flash_dq_in;
          end
          if (cyc_done) begin
            state <= h_answer;
          end
        end
        h_poll: begin
          if (sample) begin
            prev <= flash_dq_in;
          end
          if (cyc_done) begin
            // only a change between reads counts, never the bit level itself
            // the first read has no partner yet, so it never ends the poll
            if (have_prev && prev[toggle_bit] == answer[toggle_bit]) begin
              state <= h_answer;
            end else begin
              cyc_start <= 1'b1;
            end
            have_prev <= 1'b1;
            answer <= prev;
          end
        end
        h_answer: state <= h_idle;
        default: state <= h_idle;
      endcase
    end
  end

  // mode tracking; reset stands in for power-up, which leaves array mode
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ident_mode <= 1'b0;
      lockout_sent <= 1'b0;
    end else if (state == h_seq && cyc_done && step == steps - 3'd1) begin
      if (cur.op == op_ident_entry) begin
        ident_mode <= 1'b1;
      end
      if (cur.op == op_ident_exit) begin
        ident_mode <= 1'b0;
      end
      if (cur.op == op_lockout) begin
        lockout_sent <= 1'b1;
      end
    end
  end

  // pins: the polling address stays that of the request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flash_addr <= 16'h0000;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      chip_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
    end else begin
      if (state == h_seq) begin
        flash_addr <= word.addr;
        flash_dq_out <= word.data;
        flash_dq_oe <= 1'b1;
        output_enable_n <= 1'b1;
        write_enable_n <= strobe_n;
        chip_enable_n <= !cyc_busy;
      end else if (state == h_read || state == h_poll) begin
        flash_addr <= cur.addr;
        flash_dq_oe <= 1'b0;
        write_enable_n <= 1'b1;
        chip_enable_n <= 1'b0;
        output_enable_n <= strobe_n;
      end else begin
        flash_dq_oe <= 1'b0;
        chip_enable_n <= 1'b1;
        output_enable_n <= 1'b1;
        write_enable_n <= 1'b1;
      end
    end
  end

  // answer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      resp_valid <= 1'b0;
      resp_data <= 8'h00;
      resp_refused <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      resp_valid <= (state == h_answer);
      // refusal flag rides with the answer pulse, never ahead of it
      resp_refused <= (state == h_answer) && refused;
      if (state == h_answer) begin
        resp_data <= answer;
      end
      req_ready <= (state == h_idle) && !req_valid;
    end
  end

endmodule

/* File: flash_host_properties.sv */
`timescale 1ns/1ps
module flash_host_properties
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // answer side
  input wire logic resp_valid,
  input wire logic resp_refused,
  input wire logic lockout_sent,
  // flash pins
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_oe_high;
    $rose(output_enable_n) |-> output_enable_n [*8];
  endproperty
  a_oe_high: assert property (p_oe_high) else $error("oe high pulse short");
  property p_no_fight;
    !output_enable_n |-> !flash_dq_oe && write_enable_n;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("dq driven in read");
  property p_addr_read;
    !output_enable_n && $past(!output_enable_n) |-> $stable(flash_addr);
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("addr moved in read");
  property p_oe_we;
    !write_enable_n |-> output_enable_n && !chip_enable_n && flash_dq_oe;
  endproperty
  a_oe_we: assert property (p_oe_we) else $error("bad write strobes");
  property p_we_low;
    $fell(write_enable_n) |-> !write_enable_n [*5];
  endproperty
  a_we_low: assert property (p_we_low) else $error("write pulse short");
  property p_we_high;
    $rose(write_enable_n) |-> write_enable_n [*5];
  endproperty
  a_we_high: assert property (p_we_high) else $error("write gap short");
  property p_addr_write;
    !write_enable_n && $past(!write_enable_n) |-> $stable(flash_addr) && $stable(flash_dq_out);
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("write moved");
  property p_refuse;
    resp_refused |-> resp_valid && lockout_sent && chip_enable_n && $past(chip_enable_n);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad refusal");
  property p_lock_hold;
    lockout_sent |=> lockout_sent;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout lost");
endmodule

bind flash_host flash_host_properties u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .resp_valid(resp_valid), .resp_refused(resp_refused), .lockout_sent(lockout_sent),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
  .write_enable_n(write_enable_n));

/* File: flash_model.sv */
`timescale 1ns/1ps
module flash_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] maker_code = 8'h5A, // arbitrary value
  parameter logic [7:0] device_code = 8'hC3, // arbitrary value
  parameter realtime prog_ns = 2000.0,
  parameter realtime erase_ns = 6000.0
)
(
  // flash pins
  input wire logic [15:0] addr,
  input wire logic [7:0] dq_w,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  // supply and read data
  input wire logic power_good,
  output logic [7:0] dq_r
);
  logic [7:0] mem [0:65535];
  logic [2:0] step;
  logic ident, lock, tog, prog_next;
  realtime done_at;
  wire rd = !ce_n && !oe_n && we_n;
  wire [14:0] ca = addr[14:0];
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {step, ident, lock, tog, prog_next} = '0;
    done_at = 0.0;
    dq_r = 8'h00;
  end
  always @(negedge power_good) ident = 1'b0;
  always @(posedge we_n) begin
    if (!ce_n && prog_next) begin
      prog_next = 1'b0;
      if (!(lock && addr <= boot_last)) begin
        mem[addr] = mem[addr] & dq_w;
        done_at = $realtime + prog_ns;
      end
    end else if (!ce_n) begin
      case (step)
        0, 3: step = (ca == unlock_addr1 && dq_w == unlock_data1) ? step + 1 : 0;
        1, 4: step = (ca == unlock_addr2 && dq_w == unlock_data2) ? step + 1 : 0;
        2: begin
          // lockout opens its second half with its own byte
          step = (dq_w == cmd_erase_setup || dq_w == cmd_lockout) ? 3'd3 : 3'd0;
          prog_next = (dq_w == cmd_program);
          if (dq_w == cmd_ident_entry) ident = 1'b1;
          if (dq_w == cmd_ident_exit) ident = 1'b0;
        end
        default: begin
          step = 0;
          if (dq_w == cmd_lockout) lock = 1'b1;
          if (dq_w == cmd_chip_erase) begin
            foreach (mem[i]) if (!(lock && i <= boot_last)) mem[i] = 8'hFF;
            done_at = $realtime + erase_ns;
          end
        end
      endcase
    end
  end
  always @(posedge rd) begin
    if ($realtime < done_at) begin
      tog = ~tog;
      dq_r = {1'b0, tog, 6'h00};
    end else if (ident && addr[15:1] == 15'h0000) begin
      dq_r = addr[0] ? device_code : maker_code;
    end else begin
      dq_r = mem[addr];
    end
  end
  // released bus shows the inverse, so a late sample never sees stale data
  always @(negedge rd) dq_r = ~dq_r;
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
`define check(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import flash_host_pkg::*;
;
  localparam logic [7:0] maker = 8'h5A; // arbitrary value
  localparam logic [7:0] device = 8'hC3; // arbitrary value
  logic sys_clk, resetn, req_valid, power_good, ref_bit;
  host_req_t req;
  logic req_ready, resp_valid, resp_refused, ident_mode, lockout_sent;
  logic [7:0] resp_data, dq_out, dq_r, got;
  logic [15:0] addr;
  logic dq_oe, ce_n, oe_n, we_n;
  wire [7:0] bus = dq_oe ? dq_out : dq_r;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  flash_host dut (.sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_refused(resp_refused), .ident_mode(ident_mode), .lockout_sent(lockout_sent),
    .flash_addr(addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(bus),
    .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(we_n));
  flash_model #(.maker_code(maker), .device_code(device)) fm (.addr(addr), .dq_w(bus),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .power_good(power_good), .dq_r(dq_r));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // reset doubles as power loss for the flash
  task automatic do_reset();
    resetn = 1'b0;
    power_good = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 resetn = 1'b1;
    power_good = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic op(input op_t o, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin @(posedge sys_clk); #1 n++; end
    req = '{o, a, d};
    req_valid = 1'b1;
    @(posedge sys_clk);
    #1 req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 2000) begin @(posedge sys_clk); #1 n++; end
    `check(resp_valid, 1'b1)
    got = resp_data;
    ref_bit = resp_refused;
  endtask
  task automatic t_prog();
    op(op_program, 16'h2345, 8'h3C);
    `check(ref_bit, 1'b0)
    op(op_read, 16'h2345, 8'h00);
    `check(got, 8'h3C)
    $display("test prog done");
  endtask
  task automatic t_ident();
    op(op_ident_entry, 16'h0000, 8'h00);
    `check(ident_mode, 1'b1)
    op(op_read, ident_maker_addr, 8'h00);
    `check(got, maker)
    op(op_read, ident_device_addr, 8'h00);
    `check(got, device)
    op(op_ident_exit, 16'h0000, 8'h00);
    `check(ident_mode, 1'b0)
    op(op_read, 16'h2345, 8'h00);
    `check(got, 8'h3C)
    op(op_ident_entry, 16'h0000, 8'h00);
    do_reset();
    `check(ident_mode, 1'b0)
    op(op_read, 16'h0000, 8'h00);
    `check(got, 8'hFF)
    $display("test ident done");
  endtask
  task automatic t_erase();
    op(op_chip_erase, 16'h0000, 8'h00);
    op(op_read, 16'h2345, 8'h00);
    `check(got, 8'hFF)
    $display("test erase done");
  endtask
  task automatic t_lock();
    op(op_program, 16'h0010, 8'h00);
    `check(ref_bit, 1'b0)
    op(op_lockout, 16'h0000, 8'h00);
    `check(lockout_sent, 1'b1)
    `check(fm.lock, 1'b1)
    op(op_program, boot_last, 8'h00);
    `check(ref_bit, 1'b1)
    op(op_program, boot_first, 8'h12);
    `check(ref_bit, 1'b1)
    op(op_program, 16'h2000, 8'h55);
    `check(ref_bit, 1'b0)
    op(op_read, 16'h2000, 8'h00);
    `check(got, 8'h55)
    op(op_read, boot_last, 8'h00);
    `check(got, 8'hFF)
    op(op_read, boot_first, 8'h00);
    `check(got, 8'hFF)
    $display("test lock done");
  endtask
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    power_good = 1'b0;
    do_reset();
    t_prog();
    t_ident();
    t_erase();
    t_lock();
    final_report();
  end
endmodule
